// File: rtl/adcf_pkg.sv
// Summary of operation
// - calibration finish sets calibration-done flag bit 15
// - mode register write clears calibration-done flag
// - aux out-of-range conversion sets bit 13
// - range errors clamp stored result to full scale
// - in-range aux result write clears bit 13
// - primary out-of-range conversion sets bit 12
// - in-range primary result write clears bit 12
// - bit 6 follows accumulator above threshold
// - bit 4 meaningful only with comparator enabled
// - bit 4 tracks result magnitude above level
// - counting mode sets bit 4 at count target
// - enabled gross overrange sets bit 3
// - gross overrange re-evaluated every 125 us
// - bit 3 sticky until disable or gain change
// - aux result write sets aux ready bit 1
// - calibration end sets both ready flags
// - aux ready clears on aux then primary read
// - primary result write sets ready bit 0
// - primary result read clears primary ready
// - no result overwrite while ready, except powerdown
// - mask bits gate lower eight status bits
package adcf_pkg;

    // status word field positions
    localparam int STAT_W          = 16;
    localparam int BIT_CAL_DONE    = 15;
    localparam int BIT_AUX_ERR     = 13;
    localparam int BIT_PRIM_ERR    = 12;
    localparam int BIT_ACC_OVER    = 6;
    localparam int BIT_PRIM_CMP    = 4;
    localparam int BIT_GROSS_OVR   = 3;
    localparam int BIT_AUX_RDY     = 1;
    localparam int BIT_PRIM_RDY    = 0;
    localparam int IRQ_W           = 8;

    // reset value and reserved bits (14, 11..7, 5, 2)
    localparam logic [15:0] STAT_RESET  = 16'h0000;
    localparam logic [15:0] RSVD_MASK   = 16'h4fa4;
    localparam logic [7:0]  MASK_RESET  = 8'h00;

    // converter result format
    localparam int RES_W = 24;
    localparam int ACC_W = 32;
    localparam int CNT_W = 16;

    // gross overrange evaluation period
    localparam int CLK_MHZ        = 100;
    localparam int OVR_PERIOD_US  = 125;
    localparam int OVR_PERIOD_CYC = OVR_PERIOD_US * CLK_MHZ;

endpackage

// File: rtl/adcf_result_store.sv
`timescale 1ns/1ps
module adcf_result_store
    import adcf_pkg::*;
#(
    parameter int WIDTH = RES_W
) (
    // clock and reset
    input  wire logic             clock_i,
    input  wire logic             rst_n_i,
    // conversion in
    input  wire logic             load_i,
    input  wire logic             over_i,
    input  wire logic             under_i,
    input  wire logic [WIDTH-1:0] raw_i,
    // stored result out
    output logic      [WIDTH-1:0] result_o
);

    logic [WIDTH-1:0] result_q;
    logic [WIDTH-1:0] clamped;
    wire  [WIDTH-1:0] pos_fs = {1'b0, {(WIDTH-1){1'b1}}};
    wire  [WIDTH-1:0] neg_fs = {1'b1, {(WIDTH-1){1'b0}}};

    // underrange has priority in case the converter flags both
    assign clamped = under_i ? neg_fs : (over_i ? pos_fs : raw_i);

    // register only updates when the caller permits the write
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            result_q <= '0;
        end else if (load_i) begin
            result_q <= clamped;
        end
    end

    assign result_o = result_q;

endmodule

// File: rtl/adcf_status.sv
`timescale 1ns/1ps
module adcf_status
    import adcf_pkg::*;
#(
    parameter int OVR_CYC = OVR_PERIOD_CYC
) (
    // clock and reset
    input  wire logic             clock_i,
    input  wire logic             rst_n_i,
    // core register access strobes
    input  wire logic             prim_rd_i,
    input  wire logic             aux_rd_i,
    input  wire logic             mode_wr_i,
    input  wire logic             gain_change_i,
    input  wire logic [IRQ_W-1:0] irq_mask_i,
    // configuration levels
    input  wire logic             prim_en_i,
    input  wire logic             aux_en_i,
    input  wire logic             cmp_en_i,
    input  wire logic             cnt_en_i,
    input  wire logic             ovr_det_en_i,
    input  wire logic             core_pwrdn_i,
    input  wire logic [RES_W-1:0] prim_cmp_level_i,
    input  wire logic [CNT_W-1:0] cmp_count_target_i,
    input  wire logic [ACC_W-1:0] accum_threshold_i,
    input  wire logic [ACC_W-1:0] prim_accumulator_i,
    // converter events
    input  wire logic             cal_done_i,
    input  wire logic             prim_valid_i,
    input  wire logic             prim_over_i,
    input  wire logic             prim_under_i,
    input  wire logic [RES_W-1:0] prim_raw_i,
    input  wire logic             aux_valid_i,
    input  wire logic             aux_over_i,
    input  wire logic             aux_under_i,
    input  wire logic [RES_W-1:0] aux_raw_i,
    input  wire logic             gross_over_i,
    // read data and request
    output logic      [STAT_W-1:0] adc_status_word_o,
    output logic      [RES_W-1:0]  prim_result_reg_o,
    output logic      [RES_W-1:0]  aux_result_reg_o,
    output logic      [CNT_W-1:0]  cmp_count_value_o,
    output logic                   adc_irq_o
);

    // flag registers
    logic cal_done_flag_q, cal_done_flag_d;
    logic aux_conv_error_q, aux_conv_error_d;
    logic prim_conv_error_q, prim_conv_error_d;
    logic accum_over_thresh_q;
    logic prim_cmp_flag_q, prim_cmp_flag_d;
    logic gross_overrange_flag_q, gross_overrange_flag_d;
    logic aux_ready_flag_q, aux_ready_flag_d;
    logic prim_ready_flag_q, prim_ready_flag_d;
    logic aux_read_seen_q, aux_read_seen_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [$clog2(OVR_CYC)-1:0] tick_cnt_q;
    logic tick;
    logic gov_s1_q, gov_s2_q, gov_s3_q, gov_lvl_q;

    // write permission: a pending result is protected unless the core sleeps
    wire prim_load = prim_valid_i & (~prim_ready_flag_q | core_pwrdn_i);
    wire aux_load  = aux_valid_i & (~aux_ready_flag_q | core_pwrdn_i);
    wire prim_bad  = prim_over_i | prim_under_i;
    wire aux_bad   = aux_over_i | aux_under_i;

    // result holders, each clamping out-of-range conversions
    adcf_result_store #(.WIDTH(RES_W)) u_prim (
        .clock_i  (clock_i),
        .rst_n_i  (rst_n_i),
        .load_i   (prim_load),
        .over_i   (prim_over_i),
        .under_i  (prim_under_i),
        .raw_i    (prim_raw_i),
        .result_o (prim_result_reg_o)
    );
    adcf_result_store #(.WIDTH(RES_W)) u_aux (
        .clock_i  (clock_i),
        .rst_n_i  (rst_n_i),
        .load_i   (aux_load),
        .over_i   (aux_over_i),
        .under_i  (aux_under_i),
        .raw_i    (aux_raw_i),
        .result_o (aux_result_reg_o)
    );

    // calibration-done: set wins over the mode-write clear
    assign cal_done_flag_d = cal_done_i | (cal_done_flag_q & ~mode_wr_i);

    // error flags set on any bad conversion, cleared by an in-range stored write
    assign aux_conv_error_d  = (aux_valid_i & aux_bad) |
                               (aux_conv_error_q & ~(aux_load & ~aux_bad));
    assign prim_conv_error_d = (prim_valid_i & prim_bad) |
                               (prim_conv_error_q & ~(prim_load & ~prim_bad));

    // comparator magnitude; one extra bit so negative full scale does not wrap
    wire [RES_W-1:0] prim_clamped = prim_under_i ? {1'b1, {(RES_W-1){1'b0}}} :
                                    (prim_over_i ? {1'b0, {(RES_W-1){1'b1}}} : prim_raw_i);
    wire [RES_W:0]   prim_mag     = prim_clamped[RES_W-1] ? ({1'b0, ~prim_clamped} + {{RES_W{1'b0}}, 1'b1})
                                                          : {1'b0, prim_clamped};
    wire             prim_above   = prim_mag > {1'b0, prim_cmp_level_i};
    wire             cmp_event    = cmp_en_i & prim_valid_i;
    wire             cnt_hit      = (cnt_q + {{(CNT_W-1){1'b0}}, 1'b1}) >= cmp_count_target_i;

    // qualifying results in a row; a miss restarts the count
    always_comb begin
        cnt_d           = cnt_q;
        prim_cmp_flag_d = prim_cmp_flag_q;
        if (!cmp_en_i) begin
            cnt_d           = '0;
            prim_cmp_flag_d = 1'b0;
        end else if (cmp_event && !cnt_en_i) begin
            cnt_d           = '0;                                         // stale run must not carry into counting
            prim_cmp_flag_d = prim_above;
        end else if (cmp_event && prim_above) begin
            cnt_d           = cnt_hit ? cmp_count_target_i : cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
            prim_cmp_flag_d = cnt_hit;
        end else if (cmp_event) begin
            cnt_d           = '0;
            prim_cmp_flag_d = 1'b0;
        end
    end

    // evaluation tick for the overrange sampler
    assign tick = (tick_cnt_q == ($clog2(OVR_CYC))'(OVR_CYC - 1));
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
        end
    end

    // analogue detector output is asynchronous; take it only when stages agree
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            gov_s1_q  <= 1'b0;
            gov_s2_q  <= 1'b0;
            gov_s3_q  <= 1'b0;
            gov_lvl_q <= 1'b0;
        end else begin
            gov_s1_q <= gross_over_i;
            gov_s2_q <= gov_s1_q;
            gov_s3_q <= gov_s2_q;
            if (gov_s2_q == gov_s3_q) begin
                gov_lvl_q <= gov_s3_q;
            end
        end
    end

    // sticky overrange; a set on the tick beats a gain-change clear
    assign gross_overrange_flag_d = (tick & ovr_det_en_i & gov_lvl_q) |
                                    (gross_overrange_flag_q & ovr_det_en_i & ~gain_change_i);

    // ready flags; a new result or calibration end wins over the read clear
    assign aux_read_seen_d   = ~prim_rd_i & (aux_rd_i | aux_read_seen_q); // a same-cycle pair is used up
    assign aux_ready_flag_d  = (aux_load & aux_en_i) | cal_done_i |
                               (aux_ready_flag_q & ~(prim_rd_i & (aux_read_seen_q | aux_rd_i)));
    assign prim_ready_flag_d = (prim_load & prim_en_i) | cal_done_i |
                               (prim_ready_flag_q & ~prim_rd_i);

    // status flag registers
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            cal_done_flag_q        <= STAT_RESET[BIT_CAL_DONE];
            aux_conv_error_q       <= STAT_RESET[BIT_AUX_ERR];
            prim_conv_error_q      <= STAT_RESET[BIT_PRIM_ERR];
            accum_over_thresh_q    <= STAT_RESET[BIT_ACC_OVER];
            prim_cmp_flag_q        <= STAT_RESET[BIT_PRIM_CMP];
            gross_overrange_flag_q <= STAT_RESET[BIT_GROSS_OVR];
            aux_ready_flag_q       <= STAT_RESET[BIT_AUX_RDY];
            prim_ready_flag_q      <= STAT_RESET[BIT_PRIM_RDY];
            aux_read_seen_q        <= 1'b0;
            cnt_q                  <= '0;
        end else begin
            cal_done_flag_q        <= cal_done_flag_d;
            aux_conv_error_q       <= aux_conv_error_d;
            prim_conv_error_q      <= prim_conv_error_d;
            accum_over_thresh_q    <= $signed(prim_accumulator_i) > $signed(accum_threshold_i);
            prim_cmp_flag_q        <= prim_cmp_flag_d;
            gross_overrange_flag_q <= gross_overrange_flag_d;
            aux_ready_flag_q       <= aux_ready_flag_d;
            prim_ready_flag_q      <= prim_ready_flag_d;
            aux_read_seen_q        <= aux_read_seen_d;
            cnt_q                  <= cnt_d;
        end
    end

    // status word assembly; unlisted positions stay zero
    always_comb begin
        adc_status_word_o                = '0;
        adc_status_word_o[BIT_CAL_DONE]  = cal_done_flag_q;
        adc_status_word_o[BIT_AUX_ERR]   = aux_conv_error_q;
        adc_status_word_o[BIT_PRIM_ERR]  = prim_conv_error_q;
        adc_status_word_o[BIT_ACC_OVER]  = accum_over_thresh_q;
        adc_status_word_o[BIT_PRIM_CMP]  = prim_cmp_flag_q;
        adc_status_word_o[BIT_GROSS_OVR] = gross_overrange_flag_q;
        adc_status_word_o[BIT_AUX_RDY]   = aux_ready_flag_q;
        adc_status_word_o[BIT_PRIM_RDY]  = prim_ready_flag_q;
    end

    // request line: reserved positions can never raise it
    assign adc_irq_o = |(adc_status_word_o[IRQ_W-1:0] & irq_mask_i & ~RSVD_MASK[IRQ_W-1:0]);
    assign cmp_count_value_o = cnt_q;

    property p_cal_set;
        @(posedge clock_i) disable iff (!rst_n_i) cal_done_i |=> adc_status_word_o[BIT_CAL_DONE];
    endproperty
    a_cal_set: assert property (p_cal_set) else $error("cal done flag not set");

    property p_cal_clr;
        @(posedge clock_i) disable iff (!rst_n_i)
            (mode_wr_i && !cal_done_i) |=> !adc_status_word_o[BIT_CAL_DONE];
    endproperty
    a_cal_clr: assert property (p_cal_clr) else $error("cal done flag not cleared by mode write");

    property p_aux_err;
        @(posedge clock_i) disable iff (!rst_n_i) (aux_valid_i && aux_bad) |=> adc_status_word_o[BIT_AUX_ERR];
    endproperty
    a_aux_err: assert property (p_aux_err) else $error("aux error flag not set");

    property p_clamp;
        @(posedge clock_i) disable iff (!rst_n_i)
            (prim_load && prim_under_i) |=> prim_result_reg_o == {1'b1, {(RES_W-1){1'b0}}};
    endproperty
    a_clamp: assert property (p_clamp) else $error("underrange result not clamped");

    property p_prim_err_clr;
        @(posedge clock_i) disable iff (!rst_n_i)
            (prim_load && !prim_bad) |=> !adc_status_word_o[BIT_PRIM_ERR];
    endproperty
    a_prim_err_clr: assert property (p_prim_err_clr) else $error("primary error flag not cleared");

    property p_accum;
        @(posedge clock_i) disable iff (!rst_n_i)
            ##1 adc_status_word_o[BIT_ACC_OVER] ==
                ($signed($past(prim_accumulator_i)) > $signed($past(accum_threshold_i)));
    endproperty
    a_accum: assert property (p_accum) else $error("accumulator flag mismatch");

    property p_ovr_sticky;
        @(posedge clock_i) disable iff (!rst_n_i)
            (gross_overrange_flag_q && ovr_det_en_i && !gain_change_i) |=> gross_overrange_flag_q;
    endproperty
    a_ovr_sticky: assert property (p_ovr_sticky) else $error("overrange flag dropped");

    property p_ovr_tick;
        @(posedge clock_i) disable iff (!rst_n_i)
            (!gross_overrange_flag_q && !tick) |=> !gross_overrange_flag_q;
    endproperty
    a_ovr_tick: assert property (p_ovr_tick) else $error("overrange set off tick");

    property p_prim_rd;
        @(posedge clock_i) disable iff (!rst_n_i)
            (prim_rd_i && !prim_load && !cal_done_i) |=> !prim_ready_flag_q;
    endproperty
    a_prim_rd: assert property (p_prim_rd) else $error("primary ready not cleared by read");

    property p_aux_pair;
        @(posedge clock_i) disable iff (!rst_n_i)
            (aux_rd_i && !prim_rd_i) ##1 (prim_rd_i && !aux_load && !cal_done_i) |=> !aux_ready_flag_q;
    endproperty
    a_aux_pair: assert property (p_aux_pair) else $error("aux ready not cleared by read pair");

    property p_no_overwrite;
        @(posedge clock_i) disable iff (!rst_n_i)
            (prim_ready_flag_q && !core_pwrdn_i) |=> $stable(prim_result_reg_o);
    endproperty
    a_no_overwrite: assert property (p_no_overwrite) else $error("pending primary result overwritten");

    property p_rsvd;
        @(posedge clock_i) disable iff (!rst_n_i) (adc_status_word_o & RSVD_MASK) == '0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved status bit set");

    property p_aux_err_clr;
        @(posedge clock_i) disable iff (!rst_n_i)
            (aux_load && !aux_bad) |=> !adc_status_word_o[BIT_AUX_ERR];
    endproperty
    a_aux_err_clr: assert property (p_aux_err_clr) else $error("aux error flag not cleared");

    property p_prim_err;
        @(posedge clock_i) disable iff (!rst_n_i)
            (prim_valid_i && prim_bad) |=> adc_status_word_o[BIT_PRIM_ERR];
    endproperty
    a_prim_err: assert property (p_prim_err) else $error("primary error flag not set");

    property p_aux_clamp;
        @(posedge clock_i) disable iff (!rst_n_i)
            (aux_load && aux_under_i) |=> aux_result_reg_o == {1'b1, {(RES_W-1){1'b0}}};
    endproperty
    a_aux_clamp: assert property (p_aux_clamp) else $error("aux underrange result not clamped");

    property p_cmp_off;
        @(posedge clock_i) disable iff (!rst_n_i)
            !cmp_en_i |=> !adc_status_word_o[BIT_PRIM_CMP];
    endproperty
    a_cmp_off: assert property (p_cmp_off) else $error("comparator flag set while disabled");

    property p_cmp_level;
        @(posedge clock_i) disable iff (!rst_n_i)
            (cmp_event && !cnt_en_i && !prim_bad && !prim_raw_i[RES_W-1] && (prim_raw_i > prim_cmp_level_i))
            |=> adc_status_word_o[BIT_PRIM_CMP];
    endproperty
    a_cmp_level: assert property (p_cmp_level) else $error("comparator flag not set above level");

    property p_cmp_count;
        @(posedge clock_i) disable iff (!rst_n_i)
            ($rose(adc_status_word_o[BIT_PRIM_CMP]) && $past(cnt_en_i) && $past(cmp_en_i))
            |-> cmp_count_value_o == $past(cmp_count_target_i);
    endproperty
    a_cmp_count: assert property (p_cmp_count) else $error("comparator flag set before count target");

    property p_ovr_set;
        @(posedge clock_i) disable iff (!rst_n_i)
            (tick && ovr_det_en_i && gov_lvl_q) |=> adc_status_word_o[BIT_GROSS_OVR];
    endproperty
    a_ovr_set: assert property (p_ovr_set) else $error("overrange flag not set on tick");

    property p_ovr_off;
        @(posedge clock_i) disable iff (!rst_n_i)
            !ovr_det_en_i |=> !adc_status_word_o[BIT_GROSS_OVR];
    endproperty
    a_ovr_off: assert property (p_ovr_off) else $error("overrange flag kept while detect disabled");

    property p_aux_rdy;
        @(posedge clock_i) disable iff (!rst_n_i)
            (aux_load && aux_en_i) |=> adc_status_word_o[BIT_AUX_RDY];
    endproperty
    a_aux_rdy: assert property (p_aux_rdy) else $error("aux ready not set by stored result");

    property p_cal_rdy;
        @(posedge clock_i) disable iff (!rst_n_i)
            cal_done_i |=> (adc_status_word_o[BIT_AUX_RDY] && adc_status_word_o[BIT_PRIM_RDY]);
    endproperty
    a_cal_rdy: assert property (p_cal_rdy) else $error("ready flags not set by calibration end");

    property p_prim_rdy;
        @(posedge clock_i) disable iff (!rst_n_i)
            (prim_load && prim_en_i) |=> adc_status_word_o[BIT_PRIM_RDY];
    endproperty
    a_prim_rdy: assert property (p_prim_rdy) else $error("primary ready not set by stored result");

    property p_irq;
        @(posedge clock_i) disable iff (!rst_n_i)
            adc_irq_o == |(adc_status_word_o[IRQ_W-1:0] & irq_mask_i);
    endproperty
    a_irq: assert property (p_irq) else $error("request line disagrees with masked flags");

endmodule

// File: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import adcf_pkg::*;
    // stimulus levels and strobes driven from the bench, then the DUT outputs and the check counters
    logic              clock_i, rst_n_i, prim_rd_i, aux_rd_i, mode_wr_i, gain_change_i;
    logic              prim_en_i, aux_en_i, cmp_en_i, cnt_en_i, ovr_det_en_i, core_pwrdn_i;
    logic              cal_done_i, prim_valid_i, prim_over_i, prim_under_i;
    logic              aux_valid_i, aux_over_i, aux_under_i, gross_over_i;
    logic [IRQ_W-1:0]  irq_mask_i;
    logic [RES_W-1:0]  prim_cmp_level_i, prim_raw_i, aux_raw_i;
    logic [CNT_W-1:0]  cmp_count_target_i;
    logic [ACC_W-1:0]  accum_threshold_i, prim_accumulator_i;
    logic [STAT_W-1:0] adc_status_word_o;
    logic [RES_W-1:0]  prim_result_reg_o, aux_result_reg_o;
    logic [CNT_W-1:0]  cmp_count_value_o;
    logic              adc_irq_o;
    int                n_mismatch, n_checks, n;

    // short overrange period keeps the sticky-flag waits brief
    adcf_status #(.OVR_CYC(16)) i_adcf_status (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .prim_rd_i(prim_rd_i), .aux_rd_i(aux_rd_i),
        .mode_wr_i(mode_wr_i), .gain_change_i(gain_change_i), .irq_mask_i(irq_mask_i),
        .prim_en_i(prim_en_i), .aux_en_i(aux_en_i), .cmp_en_i(cmp_en_i), .cnt_en_i(cnt_en_i),
        .ovr_det_en_i(ovr_det_en_i), .core_pwrdn_i(core_pwrdn_i), .prim_cmp_level_i(prim_cmp_level_i),
        .cmp_count_target_i(cmp_count_target_i), .accum_threshold_i(accum_threshold_i),
        .prim_accumulator_i(prim_accumulator_i), .cal_done_i(cal_done_i), .prim_valid_i(prim_valid_i),
        .prim_over_i(prim_over_i), .prim_under_i(prim_under_i), .prim_raw_i(prim_raw_i),
        .aux_valid_i(aux_valid_i), .aux_over_i(aux_over_i), .aux_under_i(aux_under_i),
        .aux_raw_i(aux_raw_i), .gross_over_i(gross_over_i), .adc_status_word_o(adc_status_word_o),
        .prim_result_reg_o(prim_result_reg_o), .aux_result_reg_o(aux_result_reg_o),
        .cmp_count_value_o(cmp_count_value_o), .adc_irq_o(adc_irq_o));

    always #5 clock_i = ~clock_i;

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task conclude;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // one-cycle event helpers conv_p, conv_a, rd and ev; outputs are sampled 1 ns after the edge that takes the event
    task idle(input int c);
        repeat (c) @(posedge clock_i);
        #1;
    endtask
    task conv_p(input logic [1:0] ou, input logic [23:0] raw);
        @(posedge clock_i);
        {prim_valid_i, prim_over_i, prim_under_i, prim_raw_i} <= {1'h1, ou, raw};
        @(posedge clock_i);
        prim_valid_i <= 1'h0;
        #1;
    endtask
    task conv_a(input logic [1:0] ou, input logic [23:0] raw);
        @(posedge clock_i);
        {aux_valid_i, aux_over_i, aux_under_i, aux_raw_i} <= {1'h1, ou, raw};
        @(posedge clock_i);
        aux_valid_i <= 1'h0;
        #1;
    endtask
    task rd(input logic p, input logic a);
        @(posedge clock_i);
        {prim_rd_i, aux_rd_i} <= {p, a};
        @(posedge clock_i);
        {prim_rd_i, aux_rd_i} <= 2'h0;
        #1;
    endtask
    task ev(input logic [2:0] e);
        @(posedge clock_i);
        {cal_done_i, mode_wr_i, gain_change_i} <= e;
        @(posedge clock_i);
        {cal_done_i, mode_wr_i, gain_change_i} <= 3'h0;
        #1;
    endtask
    task msk(input logic [7:0] m, input logic e);
        @(posedge clock_i);
        irq_mask_i <= m;
        #1;
        chk(adc_irq_o, e);
    endtask
    task acc(input logic [31:0] v, input logic e);
        @(posedge clock_i);
        prim_accumulator_i <= v;
        idle(2);
        chk(adc_status_word_o[BIT_ACC_OVER], e);
    endtask
    // bounded wait for the overrange flag; n tells how long it took
    task wait_ovr;
        n = 0;
        while (adc_status_word_o[BIT_GROSS_OVR] !== 1'h1 && n < 40) begin
            idle(1);
            n++;
        end
    endtask

    task t_prim;
        @(posedge clock_i);
        prim_en_i <= 1'h1;
        conv_p(2'h0, 24'h123456);
        chk(prim_result_reg_o, 24'h123456);
        chk(adc_status_word_o[BIT_PRIM_RDY], 1'h1);
        conv_p(2'h0, 24'h654321);
        chk(prim_result_reg_o, 24'h123456);
        rd(1'h1, 1'h0);
        chk(adc_status_word_o[BIT_PRIM_RDY], 1'h0);
        conv_p(2'h2, 24'h000001);
        chk(prim_result_reg_o, 24'h7fffff);
        chk(adc_status_word_o[BIT_PRIM_ERR], 1'h1);
        rd(1'h1, 1'h0);
        conv_p(2'h1, 24'h000002);
        chk(prim_result_reg_o, 24'h800000);
        rd(1'h1, 1'h0);
        conv_p(2'h0, 24'h000abc);
        chk(adc_status_word_o[BIT_PRIM_ERR], 1'h0);
        @(posedge clock_i);
        core_pwrdn_i <= 1'h1;
        conv_p(2'h0, 24'h00beef);
        chk(prim_result_reg_o, 24'h00beef);
        @(posedge clock_i);
        core_pwrdn_i <= 1'h0;
        rd(1'h1, 1'h0);
        @(posedge clock_i);
        prim_en_i <= 1'h0;
        conv_p(2'h0, 24'h000321);
        chk(adc_status_word_o[BIT_PRIM_RDY], 1'h0);
    endtask

    task t_aux;
        @(posedge clock_i);
        aux_en_i <= 1'h1;
        conv_a(2'h2, 24'h000005);
        chk(aux_result_reg_o, 24'h7fffff);
        chk(adc_status_word_o[BIT_AUX_ERR], 1'h1);
        chk(adc_status_word_o[BIT_AUX_RDY], 1'h1);
        rd(1'h1, 1'h0);
        chk(adc_status_word_o[BIT_AUX_RDY], 1'h1);
        rd(1'h0, 1'h1);
        chk(adc_status_word_o[BIT_AUX_RDY], 1'h1);
        rd(1'h1, 1'h0);
        chk(adc_status_word_o[BIT_AUX_RDY], 1'h0);
        conv_a(2'h0, 24'h000777);
        chk(adc_status_word_o[BIT_AUX_ERR], 1'h0);
        rd(1'h0, 1'h1);
        rd(1'h1, 1'h0);
        rd(1'h1, 1'h1);
        conv_a(2'h0, 24'h000888);
        rd(1'h1, 1'h0);
        chk(adc_status_word_o[BIT_AUX_RDY], 1'h1);
        rd(1'h0, 1'h1);
        rd(1'h1, 1'h0);
    endtask

    task t_cal;
        ev(3'h4);
        chk(adc_status_word_o & 16'h8003, 16'h8003);
        msk(8'h04, 1'h0);
        msk(8'h02, 1'h1);
        msk(8'h00, 1'h0);
        ev(3'h2);
        chk(adc_status_word_o[BIT_CAL_DONE], 1'h0);
        rd(1'h0, 1'h1);
        rd(1'h1, 1'h0);
        chk(adc_status_word_o[1:0], 2'h0);
    endtask

    task t_cmp;
        @(posedge clock_i);
        cmp_en_i <= 1'h1;
        conv_p(2'h0, 24'hfffe00);
        chk(adc_status_word_o[BIT_PRIM_CMP], 1'h1);
        conv_p(2'h0, 24'h000100);
        chk(adc_status_word_o[BIT_PRIM_CMP], 1'h0);
        @(posedge clock_i);
        cnt_en_i <= 1'h1;
        conv_p(2'h0, 24'h000100);
        conv_p(2'h0, 24'h000200);
        conv_p(2'h0, 24'h000200);
        chk(adc_status_word_o[BIT_PRIM_CMP], 1'h0);
        conv_p(2'h0, 24'h000200);
        chk(adc_status_word_o[BIT_PRIM_CMP], 1'h1);
        chk(cmp_count_value_o, 16'h0003);
        @(posedge clock_i);
        {cmp_en_i, cnt_en_i} <= 2'h0;
        idle(2);
        chk(adc_status_word_o[BIT_PRIM_CMP], 1'h0);
    endtask

    task t_ovr;
        @(posedge clock_i);
        {ovr_det_en_i, gross_over_i} <= 2'h3;
        wait_ovr;
        chk(adc_status_word_o[BIT_GROSS_OVR], 1'h1);
        chk(n <= 24, 1'h1);
        @(posedge clock_i);
        gross_over_i <= 1'h0;
        idle(40);
        chk(adc_status_word_o[BIT_GROSS_OVR], 1'h1);
        ev(3'h1);
        chk(adc_status_word_o[BIT_GROSS_OVR], 1'h0);
        @(posedge clock_i);
        gross_over_i <= 1'h1;
        wait_ovr;
        chk(adc_status_word_o[BIT_GROSS_OVR], 1'h1);
        chk(adc_status_word_o & RSVD_MASK, 16'h0000);
        @(posedge clock_i);
        ovr_det_en_i <= 1'h0;
        idle(2);
        chk(adc_status_word_o[BIT_GROSS_OVR], 1'h0);
        idle(40);
        chk(adc_status_word_o[BIT_GROSS_OVR], 1'h0);
    endtask

    // a hung wait must still end the run through the common verdict
    initial begin
        #100000;
        n_mismatch++;
        conclude;
    end

    initial begin
        {clock_i, rst_n_i, prim_rd_i, aux_rd_i, mode_wr_i, gain_change_i, prim_en_i, aux_en_i} = 8'h00;
        {cmp_en_i, cnt_en_i, ovr_det_en_i, core_pwrdn_i, cal_done_i, prim_valid_i} = 6'h00;
        {prim_over_i, prim_under_i, aux_valid_i, aux_over_i, aux_under_i, gross_over_i} = 6'h00;
        {irq_mask_i, prim_raw_i, aux_raw_i, prim_accumulator_i} = '0;
        prim_cmp_level_i = 24'h000100;
        cmp_count_target_i = 16'h0003;
        accum_threshold_i = 32'h00000064;
        n_mismatch = 0;
        n_checks = 0;
        repeat (3) @(posedge clock_i);
        rst_n_i <= 1'h1;
        #1;
        chk(adc_status_word_o, 16'h0000);
        chk(adc_irq_o, 1'h0);
        t_prim;
        t_aux;
        t_cal;
        acc(32'h00000065, 1'h1);
        acc(32'h00000064, 1'h0);
        acc(32'hffffffff, 1'h0);
        t_cmp;
        t_ovr;
        conclude;
    end
endmodule
